/* fbs_pkg.sv */
// Package for the flash block-select and RAM overlay control block
package fbs_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_MODE_CTRL   = 8'h00;
  localparam logic [7:0] OFF_LARGE_SEL   = 8'h04;
  localparam logic [7:0] OFF_SMALL_SEL   = 8'h08;
  localparam logic [7:0] OFF_RAM_CTRL    = 8'h0C;
  localparam logic [7:0] OFF_STATUS      = 8'h10;
  // ---------------------------------------------------------------
  // Mode control fields
  // ---------------------------------------------------------------
  localparam int MC_PROG_BIT        = 0;
  localparam int MC_ERASE_BIT       = 1;
  localparam int MC_PVERIFY_BIT     = 2;
  localparam int MC_EVERIFY_BIT     = 3;
  localparam int MC_SUPPLY_BIT      = 6;
  localparam int MC_HIGHV_BIT       = 7;
  // ---------------------------------------------------------------
  // RAM control fields
  // ---------------------------------------------------------------
  localparam int RC_ERR_BIT         = 7;
  localparam int RC_SEL_BIT         = 3;
  localparam logic [7:0] RC_RSVD_ONES = 8'h70;
  // ---------------------------------------------------------------
  // Reset and disabled values
  // ---------------------------------------------------------------
  localparam logic [7:0] SEL_RESET    = 8'h00;
  localparam logic [7:0] SEL_DISABLED = 8'hFF;
  localparam logic [3:0] MODE_RESET   = 4'h0;
  localparam logic [3:0] OVL_RESET    = 4'h0;
  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  localparam logic [23:0] RAM_HOME     = 24'hFF_F000;
  localparam logic [23:0] OVL_BASE     = 24'h01_F000;
  localparam logic [23:0] SMALL_BASE   = 24'h01_F000;
  localparam logic [23:0] LARGE7_END   = 24'h01_EFFF;
  localparam int          LARGE_SHIFT  = 14;
  localparam int          SMALL_SHIFT  = 9;
  localparam int          WIN_BYTES    = 512;
  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* fbs_ctrl.sv */
// Flash block-select, mode control and RAM overlay register block
// How it works
// - Program bit enters program mode, resets 0
// - Large select clears on reset, standby, supply
// - Small select clears under same conditions
// - Set select bit enables its block
// - Flash disabled: selects read ones, ignore writes
// - Large bits map 16K regions, bit7 12K
// - Small bits map 512-byte regions from 1F000
// - Error flag blocks program and erase
// - Flash read during operation sets error
// - Exception before operation sets error
// - Sleep during operation sets error
// - Bus grant during operation sets error
// - Error clears only on reset, hardware standby
// - Flash read during operation is undefined
// - Reserved RAM control bits read one
// - Overlay select protects every flash block
// - Overlay bits clear on reset, hardware standby
// - Overlay window placed at 1F000 plus 512*n
// - Verify and erase bits enter their modes
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
module fbs_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        flash_enabled,
  input  wire logic        high_volt_present,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic        flash_array_read,
  input  wire logic        overlay_hit,
  input  wire logic        exception_taken,
  input  wire logic        sleep_exec,
  input  wire logic        bus_granted,
  input  wire logic [23:0] cpu_addr,
  output logic [7:0]       large_block_bits,
  output logic [7:0]       small_block_bits,
  output logic             program_mode,
  output logic             erase_mode,
  output logic             program_verify_bit,
  output logic             erase_verify_bit,
  output logic             prog_supply_enable,
  output logic             flash_error_flag,
  output logic             write_allowed,
  output logic             ram_window_hit,
  output logic             read_data_invalid
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic       fen_s;
  logic       hv_s;
  logic       hws_s;
  logic       sws_s;
  logic       frd_s;
  logic       ovh_s;
  logic       exc_s;
  logic       slp_s;
  logic       bgr_s;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {flash_enabled, high_volt_present, hw_standby, sw_standby,
                  flash_array_read, overlay_hit, exception_taken, sleep_exec,
                  bus_granted};
      sync2_q <= sync1_q;
    end
  end

  assign {fen_s, hv_s, hws_s, sws_s, frd_s, ovh_s, exc_s, slp_s, bgr_s} = sync2_q;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [3:0] mode_q;
  logic       supply_q;
  logic [7:0] large_q;
  logic [7:0] small_q;
  logic       err_q;
  logic [3:0] ovl_q;
  logic       op_active;
  logic       sel_clear;

  assign op_active = mode_q[fbs_pkg::MC_PROG_BIT] | mode_q[fbs_pkg::MC_ERASE_BIT];
  // Block selects cleared by standby or supply state
  assign sel_clear = hws_s | sws_s | ~hv_s | (hv_s & ~supply_q);

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic       aw_held_q;
  logic       w_held_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic       wstrb0_q;
  logic       do_write;
  logic       wr_hit;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
  assign do_write      = aw_held_q & w_held_q & ~s_axi_bvalid;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == fbs_pkg::OFF_MODE_CTRL) || (a == fbs_pkg::OFF_LARGE_SEL) ||
                  (a == fbs_pkg::OFF_SMALL_SEL) || (a == fbs_pkg::OFF_RAM_CTRL) ||
                  (a == fbs_pkg::OFF_STATUS);
  endfunction

  assign wr_hit = addr_mapped(awaddr_q);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fbs_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? fbs_pkg::RESP_OKAY : fbs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = do_write & wstrb0_q;

  // ---------------------------------------------------------------
  // Mode control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q   <= fbs_pkg::MODE_RESET;
      supply_q <= 1'b0;
    end else if (hws_s || sws_s || !hv_s || !fen_s) begin
      mode_q   <= fbs_pkg::MODE_RESET;
      supply_q <= 1'b0;
    end else if (wr_en && awaddr_q == fbs_pkg::OFF_MODE_CTRL) begin
      mode_q   <= wdata_q[3:0];
      supply_q <= wdata_q[fbs_pkg::MC_SUPPLY_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Block select registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || sel_clear) begin
      large_q <= fbs_pkg::SEL_RESET;
      small_q <= fbs_pkg::SEL_RESET;
    end else if (wr_en && fen_s) begin
      if (awaddr_q == fbs_pkg::OFF_LARGE_SEL)
        large_q <= wdata_q;
      if (awaddr_q == fbs_pkg::OFF_SMALL_SEL)
        small_q <= wdata_q;
    end
  end

  // ---------------------------------------------------------------
  // RAM control: overlay and error flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || hws_s) begin
      ovl_q <= fbs_pkg::OVL_RESET;
    end else if (wr_en && awaddr_q == fbs_pkg::OFF_RAM_CTRL) begin
      ovl_q <= wdata_q[3:0];
    end
  end

  logic err_event;
  assign err_event = op_active & ((frd_s & ~ovh_s) | slp_s | bgr_s);

  logic exc_arm_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exc_arm_q <= 1'b0;
    end else begin
      exc_arm_q <= exc_s;
    end
  end

  logic mode_rise;
  logic op_prev_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_prev_q <= 1'b0;
    end else begin
      op_prev_q <= op_active;
    end
  end
  assign mode_rise = op_active & ~op_prev_q;

  always_ff @(posedge clk_sys) begin
    if (rst || hws_s) begin
      err_q <= 1'b0;
    end else if (err_event || (mode_rise && (exc_arm_q || exc_s))) begin
      err_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the flash array
  // ---------------------------------------------------------------
  assign write_allowed = op_active & ~err_q & ~ovl_q[fbs_pkg::RC_SEL_BIT];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      large_block_bits   <= 8'h00;
      small_block_bits   <= 8'h00;
      program_mode       <= 1'b0;
      erase_mode         <= 1'b0;
      program_verify_bit <= 1'b0;
      erase_verify_bit   <= 1'b0;
      prog_supply_enable <= 1'b0;
      flash_error_flag   <= 1'b0;
      read_data_invalid  <= 1'b0;
      ram_window_hit     <= 1'b0;
    end else begin
      large_block_bits   <= write_allowed ? large_q : 8'h00;
      small_block_bits   <= write_allowed ? small_q : 8'h00;
      program_mode       <= mode_q[fbs_pkg::MC_PROG_BIT];
      erase_mode         <= mode_q[fbs_pkg::MC_ERASE_BIT];
      program_verify_bit <= mode_q[fbs_pkg::MC_PVERIFY_BIT];
      erase_verify_bit   <= mode_q[fbs_pkg::MC_EVERIFY_BIT];
      prog_supply_enable <= supply_q;
      flash_error_flag   <= err_q;
      read_data_invalid  <= op_active & frd_s & ~ovh_s;
      ram_window_hit     <= win_match(cpu_addr, ovl_q);
    end
  end

  function automatic logic win_match(input logic [23:0] a, input logic [3:0] o);
    logic [23:0] base;
    base = o[3] ? (fbs_pkg::OVL_BASE + {12'h000, o[2:0], 9'h000}) : fbs_pkg::RAM_HOME;
    win_match = (a[23:9] == base[23:9]);
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;
  logic       rd_hit;

  assign rd_hit = addr_mapped({s_axi_araddr[7:2], 2'b00});
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    case ({s_axi_araddr[7:2], 2'b00})
      fbs_pkg::OFF_MODE_CTRL:
        rd_byte = fen_s ? {hv_s, supply_q, 2'b00, mode_q} : fbs_pkg::SEL_DISABLED;
      fbs_pkg::OFF_LARGE_SEL:
        rd_byte = fen_s ? large_q : fbs_pkg::SEL_DISABLED;
      fbs_pkg::OFF_SMALL_SEL:
        rd_byte = fen_s ? small_q : fbs_pkg::SEL_DISABLED;
      fbs_pkg::OFF_RAM_CTRL:
        rd_byte = {err_q, 3'b000, ovl_q} | fbs_pkg::RC_RSVD_ONES;
      fbs_pkg::OFF_STATUS:
        rd_byte = {5'b00000, ovh_s, op_active, write_allowed};
      default:
        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= fbs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? fbs_pkg::RESP_OKAY : fbs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* fbs_ctrl_checker.sv */
// Concurrent checks on the flash block-select control block ports
module fbs_ctrl_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        hw_standby,
  input wire logic        flash_array_read,
  input wire logic        exception_taken,
  input wire logic        sleep_exec,
  input wire logic        bus_granted,
  input wire logic [7:0]  large_block_bits,
  input wire logic [7:0]  small_block_bits,
  input wire logic        program_mode,
  input wire logic        erase_mode,
  input wire logic        flash_error_flag,
  input wire logic        write_allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire ev_any = flash_array_read | exception_taken | sleep_exec | bus_granted;
  a_err_blocks_write: assert property (
    flash_error_flag |-> !write_allowed) else $error("write allowed while error set");
  a_err_needs_cause: assert property (
    $rose(flash_error_flag) |-> $past(ev_any, 2) || $past(ev_any, 3) || $past(ev_any, 4)
    || $past(ev_any, 5)) else $error("error flag rose without a cause");
  a_err_sticky: assert property (
    flash_error_flag ##1 !flash_error_flag |-> $past(hw_standby, 2) || $past(hw_standby, 3)
    || $past(hw_standby, 4)) else $error("error flag cleared without standby");
  a_err_standby_clear: assert property (
    hw_standby [*5] |-> !flash_error_flag) else $error("error flag kept in standby");
  a_sel_standby_clear: assert property (
    hw_standby [*5] |-> large_block_bits == 8'h00 && small_block_bits == 8'h00
    && !program_mode && !erase_mode) else $error("selects kept in standby");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  a_aw_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("address taken during response");
  c_err_set: cover property ($rose(flash_error_flag));
  c_write_ok: cover property (write_allowed);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == fbs_pkg::RESP_SLVERR);
endmodule

bind fbs_ctrl fbs_ctrl_checker fbs_ctrl_checker_i (.*);

/* fbs_ctrl_bench.sv */
// Self-checking bench for the flash block-select control block
module fbs_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [7:0] MC = fbs_pkg::OFF_MODE_CTRL;
  localparam logic [7:0] LS = fbs_pkg::OFF_LARGE_SEL;
  localparam logic [7:0] SS = fbs_pkg::OFF_SMALL_SEL;
  localparam logic [7:0] RC = fbs_pkg::OFF_RAM_CTRL;
  // Supply settling time, 5 us at 4 ns per cycle
  localparam int         SUPPLY_WAIT = 1250;
  logic        clk_sys = 1'h0, rst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        flash_enabled = 1'h1, high_volt_present = 1'h1;
  logic        hw_standby = 1'h0, sw_standby = 1'h0, overlay_hit = 1'h0;
  logic        flash_array_read = 1'h0, exception_taken = 1'h0;
  logic        sleep_exec = 1'h0, bus_granted = 1'h0;
  logic [23:0] cpu_addr = 24'h00_0000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  large_block_bits, small_block_bits;
  logic        program_mode, erase_mode, program_verify_bit, erase_verify_bit;
  logic        prog_supply_enable, flash_error_flag, write_allowed;
  logic        ram_window_hit, read_data_invalid;
  int          errors = 0;
  int          checked = 0;
  fbs_ctrl fbs_ctrl_i (.*);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic hang(input int n);
    if (n >= 100) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic [1:0] r;
    r = (a > fbs_pkg::OFF_STATUS) ? fbs_pkg::RESP_SLVERR : fbs_pkg::RESP_OKAY;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'h0;
        chk("bresp", 32'(s_axi_bresp), 32'(r));
      end
    end while (s_axi_bready && n < 100);
    hang(n);
  endtask
  task automatic supply_on();
    wr(MC, 8'h40);
    cyc(SUPPLY_WAIT);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    logic [1:0] r;
    r = (a > fbs_pkg::OFF_STATUS) ? fbs_pkg::RESP_SLVERR : fbs_pkg::RESP_OKAY;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'h0;
        chk("rdata", s_axi_rdata, {24'h00_0000, e});
        chk("rresp", 32'(s_axi_rresp), 32'(r));
      end
    end while (s_axi_rready && n < 100);
    hang(n);
  endtask
  task automatic hit(input logic [23:0] a, input logic e);
    cpu_addr <= a;
    cyc(3);
    chk("window", 32'(ram_window_hit), 32'(e));
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(6);
    rst <= 1'h0;
    cyc(5);
    rd(LS, 8'h00);
    rd(SS, 8'h00);
    rd(RC, 8'h70);
    rd(MC, 8'h80);
    supply_on();
    chk("supply", 32'(prog_supply_enable), 32'h1);
    wr(LS, 8'hA5);
    wr(SS, 8'h5A);
    rd(LS, 8'hA5);
    rd(SS, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      wr(MC, 8'h40 | 8'(1 << i));
      rd(MC, 8'hC0 | 8'(1 << i));
      cyc(3);
      chk("modes", 32'({erase_verify_bit, program_verify_bit, erase_mode, program_mode}),
          32'(1 << i));
    end
    wr(MC, 8'h41);
    cyc(3);
    chk("allowed", 32'(write_allowed), 32'h1);
    chk("large", 32'(large_block_bits), 32'h0000_00A5);
    chk("small", 32'(small_block_bits), 32'h0000_005A);
    wr(RC, 8'hFB);
    rd(RC, 8'h7B);
    cyc(3);
    chk("overlay_lock", 32'(write_allowed), 32'h0);
    hit(24'h01_F600, 1'h1);
    hit(24'h01_F7FF, 1'h1);
    hit(24'h01_F800, 1'h0);
    wr(RC, 8'h03);
    hit(24'hFF_F000, 1'h1);
    hit(24'h01_F600, 1'h0);
    sw_standby <= 1'h1;
    cyc(5);
    sw_standby <= 1'h0;
    cyc(5);
    rd(RC, 8'h73);
    rd(LS, 8'h00);
    supply_on();
    wr(MC, 8'h41);
    {overlay_hit, flash_array_read} <= 2'h3;
    cyc(6);
    chk("overlay_undef", 32'(read_data_invalid), 32'h0);
    {overlay_hit, flash_array_read} <= 2'h0;
    cyc(5);
    chk("overlay_read", 32'(flash_error_flag), 32'h0);
    for (int i = 0; i < 4; i++) begin
      hw_standby <= 1'h1;
      cyc(5);
      hw_standby <= 1'h0;
      cyc(5);
      chk("err_clear", 32'(flash_error_flag), 32'h0);
      rd(RC, 8'h70);
      supply_on();
      {bus_granted, sleep_exec, exception_taken, flash_array_read} <= 4'(1 << i);
      wr(MC, 8'h41);
      cyc(6);
      chk("undefined", 32'(read_data_invalid), 32'(i == 0));
      {bus_granted, sleep_exec, exception_taken, flash_array_read} <= 4'h0;
      cyc(5);
      chk("err_set", 32'(flash_error_flag), 32'h1);
      chk("err_lock", 32'(write_allowed), 32'h0);
      wr(RC, 8'h00);
      rd(RC, 8'hF0);
    end
    wr(LS, 8'hA5);
    rd(LS, 8'hA5);
    high_volt_present <= 1'h0;
    cyc(5);
    rd(LS, 8'h00);
    high_volt_present <= 1'h1;
    cyc(5);
    supply_on();
    wr(SS, 8'h5A);
    rd(SS, 8'h5A);
    wr(MC, 8'h00);
    chk("supply_off", 32'(prog_supply_enable), 32'h0);
    rd(SS, 8'h00);
    flash_enabled <= 1'h0;
    cyc(5);
    wr(LS, 8'h00);
    rd(LS, 8'hFF);
    rd(SS, 8'hFF);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h00);
    wrap_up();
  end
endmodule
